// ---- rlac_cmp.sv ----
`timescale 1ns/10ps
module rlac_cmp #(
  parameter int THR_W = 12,
  parameter int PAD_W = 4
) (
  input  wire logic [THR_W+PAD_W-1:0] result_i,  // conversion result
  input  wire logic [THR_W-1:0]       low_thr_i, // lower threshold field
  input  wire logic [THR_W-1:0]       high_thr_i,// upper threshold field
  output logic                        under_o,   // result below limit
  output logic                        over_o     // result above limit
);
  import rlac_pkg::*;

  // pad constants are fixed at the package pad width
  if (PAD_W != $bits(PAD_LOW)) begin : g_bad_pad
    $error("pad width must match the pad constants");
  end

  // ---------------------------------------------------------------
  // widened limits
  // ---------------------------------------------------------------
  logic [THR_W+PAD_W-1:0] low_lim;
  logic [THR_W+PAD_W-1:0] high_lim;

  // pad low with zeros, high with ones
  assign low_lim  = {low_thr_i, PAD_LOW};
  assign high_lim = {high_thr_i, PAD_HIGH};

  // strict compares, equal never alerts
  assign under_o = (result_i < low_lim);
  assign over_o  = (result_i > high_lim);

endmodule // rlac_cmp

// ---- rlac_conv_src.sv ----
`timescale 1ns/10ps
module rlac_conv_src (
  input  wire logic           clk_i,  // clock
  output rlac_pkg::rlac_conv_t conv_o // conversion results
);
  import rlac_pkg::*;
  initial conv_o = '0;
  // one valid pulse per conversion, results scrambled outside it
  task automatic send(input logic [NUM_CH-1:0][RES_W-1:0] r);
    @(posedge clk_i);
    conv_o.valid <= 1'b1;
    conv_o.res   <= r;
    @(posedge clk_i);
    conv_o.valid <= 1'b0;
    conv_o.res   <= ~r;
  endtask
endmodule // rlac_conv_src

// ---- rlac_pkg.sv ----
package rlac_pkg;

  // ---------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------
  localparam int NUM_CH = 4;           // converter channels
  localparam int RES_W  = 16;          // internal comparison width
  localparam int THR_W  = 12;          // threshold field width
  localparam int PAD_W  = 4;           // widening pad width
  localparam int ADR_W  = 8;           // bus byte address width
  localparam int DAT_W  = 32;          // bus data width
  localparam int SEL_W  = 4;           // bus byte lanes
  localparam int STAT_W = 9;           // status and mask width

  // ---------------------------------------------------------------
  // field layout of the threshold words
  // ---------------------------------------------------------------
  localparam int AFLD_MSB = 15;        // address field top
  localparam int AFLD_LSB = 12;        // address field bottom
  localparam int TFLD_MSB = 11;        // threshold field top
  localparam int TFLD_LSB = 0;         // threshold field bottom
  localparam logic [PAD_W-1:0] PAD_LOW  = 4'h0;  // lower limit pad
  localparam logic [PAD_W-1:0] PAD_HIGH = 4'hF;  // upper limit pad

  // ---------------------------------------------------------------
  // reset values and register address codes
  // ---------------------------------------------------------------
  localparam logic [THR_W-1:0] LOW_RST  = 12'h800;
  localparam logic [THR_W-1:0] HIGH_RST = 12'h7FF;
  localparam logic [3:0]       AFLD_RST = 4'h0;
  localparam logic [3:0]       LOW_CODE = 4'h1;   // lower register code
  localparam logic [3:0]       HIGH_CODE = 4'h2;  // upper register code
  localparam logic [1:0]       CTRL_RST = 2'h1;   // compare on, no freeze
  localparam int               MISS_BIT = 8;      // bad address flag

  // ---------------------------------------------------------------
  // bus byte offsets
  // ---------------------------------------------------------------
  localparam logic [ADR_W-1:0] OFS_THR  = 8'h00;  // threshold write port
  localparam logic [ADR_W-1:0] OFS_LOW  = 8'h04;  // lower readback
  localparam logic [ADR_W-1:0] OFS_HIGH = 8'h08;  // upper readback
  localparam logic [ADR_W-1:0] OFS_STAT = 8'h0C;  // alert status
  localparam logic [ADR_W-1:0] OFS_MASK = 8'h10;  // interrupt mask
  localparam logic [ADR_W-1:0] OFS_CTRL = 8'h14;  // control
  localparam logic [ADR_W-1:0] OFS_RES  = 8'h20;  // first result word

  // ---------------------------------------------------------------
  // carriers and states
  // ---------------------------------------------------------------
  typedef struct packed {
    logic             cyc;
    logic             stb;
    logic             we;
    logic [ADR_W-1:0] adr;
    logic [SEL_W-1:0] sel;
    logic [DAT_W-1:0] dat;
  } rlac_wb_req_t;

  typedef struct packed {
    logic                         valid;
    logic [NUM_CH-1:0][RES_W-1:0] res;
  } rlac_conv_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } rlac_bus_st_t;

endpackage

// ---- rlac_sticky.sv ----
`timescale 1ns/10ps
module rlac_sticky #(
  parameter int W = 9
) (
  input  wire logic         clk_i,   // clock
  input  wire logic         rst_i,   // sync reset, high
  input  wire logic         ce_i,    // clock enable
  input  wire logic [W-1:0] set_i,   // event pulses
  input  wire logic [W-1:0] clr_i,   // clear pulses
  input  wire logic [W-1:0] mask_i,  // interrupt enables
  output logic      [W-1:0] flags_o, // sticky flags
  output logic              irq_o    // level interrupt
);
  import rlac_pkg::*;

  logic [W-1:0] flags_q;
  logic [W-1:0] flags_d;

  // set wins over a clear in the same cycle
  assign flags_d = (flags_q & ~clr_i) | set_i;
  assign flags_o = flags_q;
  assign irq_o   = |(flags_q & mask_i);

  // flag storage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags_q <= '0;
    end else if (ce_i) begin
      flags_q <= flags_d;
    end
  end

endmodule // rlac_sticky

// ---- rlac_top.sv ----
// Added by the designer: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/10ps
module rlac_top #(
  parameter int NCH = rlac_pkg::NUM_CH,
  parameter int RW  = rlac_pkg::RES_W,
  parameter int TW  = rlac_pkg::THR_W,
  parameter logic [3:0] LOW_SEL  = rlac_pkg::LOW_CODE,
  parameter logic [3:0] HIGH_SEL = rlac_pkg::HIGH_CODE
) (
  input  wire logic                 clk_i,    // clock, 20 MHz
  input  wire logic                 rst_i,    // sync reset, high
  input  wire logic                 ce_i,     // clock enable
  input  wire rlac_pkg::rlac_wb_req_t wb_i,   // bus request
  output logic [rlac_pkg::DAT_W-1:0] wb_dat_o,// bus read data
  output logic                      wb_ack_o, // bus acknowledge
  input  wire rlac_pkg::rlac_conv_t conv_i,   // conversion results
  output logic                      alert_o,  // any channel flag set
  output logic                      irq_o     // masked interrupt
);
  import rlac_pkg::*;

  // ---------------------------------------------------------------
  // local bit positions
  // ---------------------------------------------------------------
  localparam int BYTE_W   = 8;   // one bus byte lane
  localparam int WORD_SH  = 2;   // byte offset to word index shift
  localparam int EN_BIT   = 0;   // ctrl compare enable
  localparam int HOLD_BIT = 1;   // ctrl result freeze
  localparam int CTRL_W   = 2;   // ctrl register width

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  if (RW != TW + PAD_W) begin : g_bad_width
    $error("result width must equal threshold width plus pad");
  end
  if (NCH < 1 || 2 * NCH > MISS_BIT) begin : g_bad_nch
    $error("channel count does not fit the status layout");
  end
  if (LOW_SEL == HIGH_SEL) begin : g_bad_code
    $error("threshold address codes must differ");
  end
  if (TW != TFLD_MSB - TFLD_LSB + 1) begin : g_bad_thr
    $error("threshold width does not match field layout");
  end
  if (NCH > NUM_CH || RW != RES_W) begin : g_bad_carrier
    $error("channel count or width exceeds the result carrier");
  end
  if (STAT_W <= BYTE_W || STAT_W <= MISS_BIT) begin : g_bad_stat
    $error("status layout needs a second mask lane");
  end

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  rlac_bus_st_t       bus_q;
  rlac_bus_st_t       bus_d;
  logic [DAT_W-1:0]   dat_q;
  logic [DAT_W-1:0]   dat_d;
  logic [3:0]         low_afld_q;
  logic [TW-1:0]      low_thr_q;
  logic [3:0]         high_afld_q;
  logic [TW-1:0]      high_thr_q;
  logic [STAT_W-1:0]  mask_q;
  logic [CTRL_W-1:0]  ctrl_q;
  logic [STAT_W-1:0]  snap_q;
  logic [NCH-1:0][RW-1:0] res_q;

  logic               req;
  logic               commit;
  logic               wr_go;
  logic               rd_go;
  logic               lanes_lo;
  logic               lanes_all;
  logic [3:0]         wr_code;
  logic               hit_thr;
  logic               hit_low;
  logic               hit_high;
  logic               hit_stat;
  logic               hit_mask;
  logic               hit_ctrl;
  logic               hit_res;
  logic [ADR_W-1:0]   res_ofs;
  logic [ADR_W-WORD_SH-1:0] res_idx;
  logic               res_ok;
  logic               thr_wr;
  logic               low_wr;
  logic               high_wr;
  logic               miss_wr;
  logic               mask_wr;
  logic               ctrl_wr;
  logic               stat_rd;
  logic               cmp_en;
  logic               res_hold;
  logic               conv_go;
  logic [NCH-1:0]     under;
  logic [NCH-1:0]     over;
  logic [STAT_W-1:0]  set_ev;
  logic [STAT_W-1:0]  clr_ev;
  logic [STAT_W-1:0]  flags;
  logic [DAT_W-1:0]   rd_mux;
  logic [DAT_W-1:0]   res_word;
  logic [DAT_W-1:0]   low_word;
  logic [DAT_W-1:0]   high_word;
  logic [DAT_W-1:0]   stat_word;
  logic [DAT_W-1:0]   mask_word;
  logic [DAT_W-1:0]   ctrl_word;
  logic [TW-1:0]      wr_fld;
  logic               mask_lo_wr;
  logic               mask_hi_wr;

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  // request present, committed on the edge that sees ack
  assign req      = wb_i.cyc & wb_i.stb;
  assign commit   = req & (bus_q == BUS_ACK);
  assign wr_go    = commit & wb_i.we;
  assign rd_go    = commit & ~wb_i.we;
  assign lanes_lo = wb_i.sel[0];
  assign lanes_all = wb_i.sel[0] & wb_i.sel[1];

  // offset matches
  assign hit_thr  = (wb_i.adr == OFS_THR);
  assign hit_low  = (wb_i.adr == OFS_LOW);
  assign hit_high = (wb_i.adr == OFS_HIGH);
  assign hit_stat = (wb_i.adr == OFS_STAT);
  assign hit_mask = (wb_i.adr == OFS_MASK);
  assign hit_ctrl = (wb_i.adr == OFS_CTRL);

  // result words, one per channel from the base offset
  assign res_ofs  = wb_i.adr - OFS_RES;
  assign res_idx  = res_ofs[ADR_W-1:WORD_SH];
  assign res_ok   = (res_ofs[WORD_SH-1:0] == '0);
  assign hit_res  = (wb_i.adr >= OFS_RES) & res_ok &
                    (res_idx < (ADR_W-WORD_SH)'(NCH));

  // ---------------------------------------------------------------
  // threshold write steering
  // ---------------------------------------------------------------
  // the word's own address field picks the register
  assign wr_code  = wb_i.dat[AFLD_MSB:AFLD_LSB];
  assign wr_fld   = wb_i.dat[TFLD_MSB:TFLD_LSB];
  assign thr_wr   = wr_go & hit_thr & lanes_all;
  assign low_wr   = thr_wr & (wr_code == LOW_SEL);
  assign high_wr  = thr_wr & (wr_code == HIGH_SEL);
  assign miss_wr  = thr_wr & ~low_wr & ~high_wr;

  // mask per byte lane, control on the low lane
  assign mask_wr    = wr_go & hit_mask;
  assign mask_lo_wr = mask_wr & wb_i.sel[0];
  assign mask_hi_wr = mask_wr & wb_i.sel[1];
  assign ctrl_wr    = wr_go & hit_ctrl & lanes_lo;

  // status clears: read clears what was shown, write one clears
  assign stat_rd  = rd_go & hit_stat;
  assign clr_ev   = (stat_rd ? snap_q : '0) |
                    ((wr_go & hit_stat) ? wb_i.dat[STAT_W-1:0] : '0);

  // ---------------------------------------------------------------
  // read data selection
  // ---------------------------------------------------------------
  // register words, zeros above each field
  assign low_word  = DAT_W'({low_afld_q, low_thr_q});
  assign high_word = DAT_W'({high_afld_q, high_thr_q});
  assign stat_word = DAT_W'(flags);
  assign mask_word = DAT_W'(mask_q);
  assign ctrl_word = DAT_W'(ctrl_q);
  assign res_word  = hit_res ? DAT_W'(res_q[res_idx]) : '0;
  assign rd_mux =
    hit_low  ? low_word  :
    hit_high ? high_word :
    hit_stat ? stat_word :
    hit_mask ? mask_word :
    hit_ctrl ? ctrl_word :
    res_word;

  // ---------------------------------------------------------------
  // bus state machine
  // ---------------------------------------------------------------
  // one idle cycle to fetch data, then ack for one cycle
  always_comb begin
    bus_d = bus_q;
    dat_d = dat_q;
    unique case (bus_q)
      BUS_IDLE: begin
        if (req) begin
          bus_d = BUS_ACK;
          dat_d = wb_i.we ? '0 : rd_mux;
        end
      end
      BUS_ACK: begin
        bus_d = BUS_IDLE;
      end
      default: begin
        bus_d = BUS_IDLE;
      end
    endcase
  end

  // bus registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_q <= BUS_IDLE;
      dat_q <= '0;
    end else if (ce_i) begin
      bus_q <= bus_d;
      dat_q <= dat_d;
    end
  end

  // ack only while the request still stands
  assign wb_ack_o = (bus_q == BUS_ACK) & req;
  assign wb_dat_o = dat_q;

  // status snapshot taken with the read data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      snap_q <= '0;
    end else if (ce_i && bus_q == BUS_IDLE && req) begin
      snap_q <= flags;
    end
  end

  // ---------------------------------------------------------------
  // threshold registers
  // ---------------------------------------------------------------
  // lower register, address field kept as written
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      low_afld_q <= AFLD_RST;
      low_thr_q  <= LOW_RST;
    end else if (ce_i && low_wr) begin
      low_afld_q <= wr_code;
      low_thr_q  <= wr_fld;
    end
  end

  // upper register, address field kept as written
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      high_afld_q <= AFLD_RST;
      high_thr_q  <= HIGH_RST;
    end else if (ce_i && high_wr) begin
      high_afld_q <= wr_code;
      high_thr_q  <= wr_fld;
    end
  end

  // ---------------------------------------------------------------
  // mask and control
  // ---------------------------------------------------------------
  // mask honours its two low byte lanes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_q <= '0;
    end else if (ce_i) begin
      if (mask_lo_wr) begin
        mask_q[BYTE_W-1:0] <= wb_i.dat[BYTE_W-1:0];
      end
      if (mask_hi_wr) begin
        mask_q[STAT_W-1:BYTE_W] <= wb_i.dat[STAT_W-1:BYTE_W];
      end
    end
  end

  // bit 0 enables compares, bit 1 holds result capture
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= CTRL_RST;
    end else if (ce_i && ctrl_wr) begin
      ctrl_q <= wb_i.dat[CTRL_W-1:0];
    end
  end

  // control bits and the qualified conversion strobe
  assign cmp_en   = ctrl_q[EN_BIT];
  assign res_hold = ctrl_q[HOLD_BIT];
  assign conv_go  = conv_i.valid & cmp_en;

  // ---------------------------------------------------------------
  // per channel compare and capture
  // ---------------------------------------------------------------
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    // shared limits against this channel's result
    rlac_cmp #(
      .THR_W (TW),
      .PAD_W (PAD_W)
    ) u_cmp (
      .result_i   (conv_i.res[c]),
      .low_thr_i  (low_thr_q),
      .high_thr_i (high_thr_q),
      .under_o    (under[c]),
      .over_o     (over[c])
    );

    // even bit low alert, odd bit high alert
    assign set_ev[2*c]   = conv_go & under[c];
    assign set_ev[2*c+1] = conv_go & over[c];

    // last result kept for software
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        res_q[c] <= '0;
      end else if (ce_i && conv_i.valid && !res_hold) begin
        res_q[c] <= conv_i.res[c];
      end
    end
  end

  // unused channel slots and bad address event
  if (2 * NCH < MISS_BIT) begin : g_pad
    assign set_ev[MISS_BIT-1:2*NCH] = '0;
  end
  assign set_ev[MISS_BIT] = miss_wr;

  // ---------------------------------------------------------------
  // sticky flags and interrupt
  // ---------------------------------------------------------------
  rlac_sticky #(
    .W (STAT_W)
  ) u_sticky (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .ce_i    (ce_i),
    .set_i   (set_ev),
    .clr_i   (clr_ev),
    .mask_i  (mask_q),
    .flags_o (flags),
    .irq_o   (irq_o)
  );

  // alert pin shows any channel flag
  assign alert_o = |flags[2*NCH-1:0];

endmodule // rlac_top

// ---- rlac_top_asserts.sv ----
`timescale 1ns/10ps
module rlac_top_asserts #(
  parameter logic [3:0] LOW_SEL  = rlac_pkg::LOW_CODE,
  parameter logic [3:0] HIGH_SEL = rlac_pkg::HIGH_CODE
) (
  input wire logic                   clk_i,    // clock
  input wire logic                   rst_i,    // sync reset
  input wire logic                   ce_i,     // clock enable
  input wire rlac_pkg::rlac_wb_req_t wb_i,     // bus request
  input wire logic [31:0]            wb_dat_o, // read data
  input wire logic                   wb_ack_o, // bus ack
  input wire rlac_pkg::rlac_conv_t   conv_i,   // results
  input wire logic                   alert_o,  // alert level
  input wire logic                   irq_o     // interrupt
);
  import rlac_pkg::*;
  logic [THR_W-1:0]  low_q, high_q;
  logic [STAT_W-1:0] mask_q;
  logic              en_q, hit_lo, hit_hi;
  // ---------------------------------------------------------------
  // shadow of the writable state
  // ---------------------------------------------------------------
  wire wr_w  = wb_ack_o && wb_i.we && ce_i;
  wire thr_w = wr_w && wb_i.adr == OFS_THR && wb_i.sel[1:0] == 2'h3;
  wire rd_w  = wb_ack_o && !wb_i.we;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      low_q  <= LOW_RST;
      high_q <= HIGH_RST;
      mask_q <= '0;
      en_q   <= 1'b1;
    end else begin
      if (thr_w && wb_i.dat[15:12] == LOW_SEL) low_q <= wb_i.dat[11:0];
      if (thr_w && wb_i.dat[15:12] == HIGH_SEL) high_q <= wb_i.dat[11:0];
      if (wr_w && wb_i.adr == OFS_MASK) mask_q <= wb_i.dat[STAT_W-1:0];
      if (wr_w && wb_i.adr == OFS_CTRL) en_q <= wb_i.dat[0];
    end
  end
  // widened limits against every channel
  always_comb begin
    hit_lo = 1'b0;
    hit_hi = 1'b0;
    for (int c = 0; c < NUM_CH; c++) begin
      hit_lo = hit_lo | (conv_i.res[c] < {low_q, PAD_LOW});
      hit_hi = hit_hi | (conv_i.res[c] > {high_q, PAD_HIGH});
    end
  end
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_wait_a: assert property (wb_i.cyc && wb_i.stb && !wb_ack_o && ce_i |=> wb_ack_o)
    else $error("ack missing after request");
  ack_qual_a: assert property (wb_ack_o |-> wb_i.cyc && wb_i.stb)
    else $error("ack without request");
  under_alert_a: assert property (conv_i.valid && ce_i && en_q && hit_lo |=> alert_o)
    else $error("low alert missing");
  over_alert_a: assert property (conv_i.valid && ce_i && en_q && hit_hi |=> alert_o)
    else $error("high alert missing");
  low_read_a: assert property (rd_w && wb_i.adr == OFS_LOW |-> wb_dat_o[11:0] == low_q)
    else $error("lower readback wrong");
  high_read_a: assert property (rd_w && wb_i.adr == OFS_HIGH |-> wb_dat_o[11:0] == high_q)
    else $error("upper readback wrong");
  alert_hold_a: assert property (!rst_i && !conv_i.valid && !wb_ack_o |=> $stable(alert_o))
    else $error("alert changed without cause");
  irq_mask_a: assert property (mask_q == '0 |-> !irq_o)
    else $error("interrupt while all masked");
  reset_clear_a: assert property ($fell(rst_i) |-> !alert_o && !irq_o && !wb_ack_o)
    else $error("outputs not clear after reset");
  cover property (conv_i.valid && hit_lo);
  cover property (conv_i.valid && hit_hi);
  cover property (irq_o);
  cover property (rd_w && wb_i.adr == OFS_STAT && wb_dat_o != '0);
endmodule // rlac_top_asserts

bind rlac_top rlac_top_asserts #(.LOW_SEL(LOW_SEL), .HIGH_SEL(HIGH_SEL)) rlac_top_asserts_inst (
  .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_i(wb_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .conv_i(conv_i), .alert_o(alert_o), .irq_o(irq_o));

// ---- testbench.sv ----
`timescale 1ns/10ps
module testbench;
  import rlac_pkg::*;
  logic             clk_i = 1'b0;
  logic             rst_i = 1'b1;
  logic             ce_i  = 1'b1;
  rlac_wb_req_t     wb_q  = '0;
  rlac_conv_t       conv_w;
  logic [DAT_W-1:0] wb_dat_o, rd;
  logic             wb_ack_o, alert_o, irq_o;
  int               miscompares = 0;
  int               tests_run = 0;

  always #25 clk_i = ~clk_i;
  rlac_top rlac_top_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_i(wb_q),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .conv_i(conv_w), .alert_o(alert_o),
    .irq_o(irq_o));
  rlac_conv_src rlac_conv_src_inst (.clk_i(clk_i), .conv_o(conv_w));
  // ---------------------------------------------------------------
  // verdict, compare and bus tasks
  // ---------------------------------------------------------------
  task automatic complete_run();
    if (miscompares == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one classic cycle, held until ack is sampled
  task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] wd);
    int n;
    @(posedge clk_i);
    wb_q <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: wd};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o;
    wb_q <= '0;
    if (wb_ack_o !== 1'b1) begin
      miscompares++;
      complete_run();
    end else begin
      @(negedge clk_i);
    end
  endtask
  task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
    bus(1'b0, adr, 32'h0);
    check(rd, exp);
  endtask
  // conversion with settled outputs afterwards
  task automatic conv(input logic [NUM_CH-1:0][RES_W-1:0] r);
    rlac_conv_src_inst.send(r);
    @(negedge clk_i);
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic s_reset();
    rd_chk(OFS_LOW, 32'h0000_0800);
    rd_chk(OFS_HIGH, 32'h0000_07FF);
    rd_chk(OFS_MASK, 32'h0);
    rd_chk(OFS_STAT, 32'h0);
    check(32'(alert_o), 32'h0);
  endtask
  task automatic s_select();
    bus(1'b1, OFS_THR, {16'h0, LOW_CODE, 12'h123});
    rd_chk(OFS_LOW, {16'h0, LOW_CODE, 12'h123});
    rd_chk(OFS_HIGH, 32'h0000_07FF);
    bus(1'b1, OFS_THR, {16'h0, HIGH_CODE, 12'h456});
    rd_chk(OFS_HIGH, {16'h0, HIGH_CODE, 12'h456});
    bus(1'b1, OFS_THR, {16'h0, 4'h3, 12'h999});
    rd_chk(OFS_LOW, {16'h0, LOW_CODE, 12'h123});
    rd_chk(OFS_HIGH, {16'h0, HIGH_CODE, 12'h456});
    rd_chk(OFS_STAT, 32'h0000_0100);
    rd_chk(8'h3C, 32'h0);
  endtask
  // boundaries of both widened limits on each channel in turn
  task automatic s_limits();
    logic [NUM_CH-1:0][RES_W-1:0] r;
    logic [3:0][15:0]             v;
    logic [31:0]                  e;
    v = {16'h2010, 16'h200F, 16'h1000, 16'h0FFF};
    bus(1'b1, OFS_THR, {16'h0, LOW_CODE, 12'h100});
    bus(1'b1, OFS_THR, {16'h0, HIGH_CODE, 12'h200});
    for (int c = 0; c < NUM_CH; c++) begin
      for (int i = 0; i < 4; i++) begin
        r = {NUM_CH{16'h1800}};
        r[c] = v[i];
        e = (i == 0) ? (32'h1 << (2 * c)) : (i == 3) ? (32'h2 << (2 * c)) : 32'h0;
        conv(r);
        check(32'(alert_o), 32'(e != 0));
        rd_chk(OFS_STAT, e);
        rd_chk(OFS_STAT, 32'h0);
      end
    end
  endtask
  // sticky flags, mask, read clear and write-one clear
  task automatic s_irq();
    bus(1'b1, OFS_MASK, 32'h2);
    conv({16'h1800, 16'h1800, 16'h1800, 16'h2010});
    check(32'(irq_o), 32'h1);
    conv({NUM_CH{16'h1800}});
    check(32'(alert_o), 32'h1);
    rd_chk(OFS_STAT, 32'h2);
    check({alert_o, irq_o}, 32'h0);
    conv({16'h1800, 16'h1800, 16'h1800, 16'h0FFF});
    check({alert_o, irq_o}, 32'h2);
    bus(1'b1, OFS_STAT, 32'h1);
    check(32'(alert_o), 32'h0);
    rd_chk(OFS_MASK, 32'h2);
  endtask
  // compare enable off, then result freeze with compares on
  task automatic s_ctrl();
    rd_chk(OFS_CTRL, 32'h1);
    bus(1'b1, OFS_CTRL, 32'h0);
    conv({16'h0004, 16'h0003, 16'h0002, 16'h0001});
    check(32'(alert_o), 32'h0);
    for (int c = 0; c < NUM_CH; c++) begin
      rd_chk(OFS_RES + 8'(4 * c), 32'(c + 1));
    end
    bus(1'b1, OFS_CTRL, 32'h3);
    conv({NUM_CH{16'h0FFF}});
    rd_chk(OFS_STAT, 32'h55);
    rd_chk(OFS_RES, 32'h1);
    bus(1'b1, OFS_CTRL, 32'h1);
  endtask
  // clock enable low freezes flags and result capture
  task automatic s_freeze();
    @(posedge clk_i);
    ce_i <= 1'b0;
    conv({NUM_CH{16'h0000}});
    @(posedge clk_i);
    ce_i <= 1'b1;
    check(32'(alert_o), 32'h0);
    rd_chk(OFS_STAT, 32'h0);
    rd_chk(OFS_RES, 32'h1);
  endtask
  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    s_reset();
    s_select();
    s_limits();
    s_irq();
    s_ctrl();
    s_freeze();
    @(posedge clk_i);
    rst_i <= 1'b1;
    @(posedge clk_i);
    rst_i <= 1'b0;
    s_reset();
    complete_run();
  end
  initial begin
    repeat (100000) @(posedge clk_i);
    miscompares++;
    complete_run();
  end
endmodule // testbench
